// >>> core/scan_fetch_ctrl.sv
// Scan code generation, line fetch request, terminate catch and video blanking.
// Assumes line_blank_input and terminate_in are synchronous to mclk and that
// the scan and offset counters sit outside and advance on line_tick.
//
// Summary of operation
// - Normal rows: scan code is count minus one.
// - Top half: halve count, then subtract one.
// - Bottom half: halve count, then add four.
// - Scan code changes only on blank rise.
// - Request fetch when selected count is zero.
// - Entering scroll region sets forcing new-zone flag.
// - Row pointer load after its fetch clears flag.
// - Fetch ends at terminator or window end.
// - Line blank blanks video, clears terminate, ticks.
// - Boundary window two wide, hold window three.
// - Fetch starts three character times after blank.
// - Without terminator, fetch ends at window close.
// - Terminate input sampled on character clock.
// - Terminator ends fetch, blanks or dims video.
// - Terminate flag holds itself until cleared.
// - Terminate clear from one char after blank.
// - Video release delayed to next character clock.
// - Scroll select picks offset or base counter.
//
// Register access over AHB-Lite and the address map are this design's own decisions.
module scan_fetch_ctrl #(
  parameter int CHAR_DIV = 4
) (
  // Clock and reset.
  input  wire logic                  mclk,
  input  wire logic                  rst_b,
  // Line timing and data stream.
  input  wire logic                  line_blank_input,
  input  wire logic                  terminate_in,
  input  wire logic                  row_pointer_load,
  input  wire logic [3:0]            base_scan,
  input  wire logic [3:0]            offset_scan,
  // Row outputs.
  output logic      [3:0]            scan_code,
  output logic                       fetch_req,
  output logic                       line_tick,
  output scan_fetch_pkg::video_s     video,
  // AHB-Lite register slave.
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic                       hreadyout,
  output logic      [31:0]           hrdata,
  output logic                       hresp
);
  import scan_fetch_pkg::*;

  localparam state_s STATE_RESET = '{
    div:        8'h00,
    blank_prev: 1'b0,
    win:        WIN_IDLE,
    scan_code:  SCAN_RESET,
    line_tick:  1'b0,
    fetch:      1'b0,
    nz:         1'b0,
    nz_done:    1'b0,
    term:       1'b0,
    scroll_sel: 1'b0,
    vid_blank:  1'b1,
    video:      '{blank: 1'b1, dim: 1'b0},
    ctrl:       ctrl_s'(CTRL_RESET),
    phase:      BUS_IDLE,
    waddr:      32'h0000_0000,
    hrdata:     32'h0000_0000,
    hreadyout:  1'b1,
    hresp:      1'b0
  };
  localparam logic [7:0] DIV_LAST = 8'(CHAR_DIV - 1);

  state_s     s_q;
  state_s     s_d;
  logic       char_en;
  logic       line_rise;
  logic       bnd_win;
  logic       hold_start;
  logic       hold_end;
  logic       term_clr;
  logic       fetch_cond;
  logic [3:0] sel_cnt;
  logic [3:0] math_code;
  logic       addr_phase;

  ////////////////////////////////////////////////////////////////////////////////
  // Scan code arithmetic on the counter in use.
  scan_math u_scan_math (
    .sel_cnt (sel_cnt),
    .dh      (s_q.ctrl.dh),
    .bottom  (s_q.ctrl.bottom),
    .code    (math_code)
  );

  // Decodes that the assertions share with the next-state logic.
  assign char_en    = (s_q.div == DIV_LAST);
  assign line_rise  = line_blank_input && !s_q.blank_prev;
  assign sel_cnt    = s_q.scroll_sel ? offset_scan : base_scan;
  assign bnd_win    = (s_q.win >= BND_OPEN) && (s_q.win <= BND_CLOSE);
  assign hold_start = char_en && (s_q.win == HOLD_OPEN - 3'h1);
  assign hold_end   = char_en && (s_q.win == HOLD_CLOSE);
  // The clear waits a character so the video is already blanked by line blank.
  assign term_clr   = line_blank_input && s_q.blank_prev && (s_q.win >= TCLR_START);
  assign fetch_cond = s_q.nz || (sel_cnt == 4'h0);
  assign addr_phase = hsel && htrans[1] && hready;

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic for the whole block.
  always_comb begin
    s_d = s_q;

    // Character clock enable from the divider.
    s_d.div = char_en ? 8'h00 : s_q.div + 8'h01;

    // Line window counter, restarted by every rise of line blank.
    s_d.blank_prev = line_blank_input;
    if (line_rise) begin
      s_d.win = 3'h0;
    end else if (char_en && s_q.win != WIN_IDLE) begin
      s_d.win = s_q.win + 3'h1;
    end

    // Horizontal time reference and scan code, both on the blank rise.
    s_d.line_tick = line_rise;
    if (line_rise) begin
      s_d.scan_code = math_code;
    end

    // Scroll select moves only on a base counter boundary inside its window.
    if (bnd_win && base_scan == 4'h0) begin
      s_d.scroll_sel = s_q.ctrl.scroll;
    end

    // Terminate catch: sampled per character, latches itself, cleared by blank.
    if (term_clr) begin
      s_d.term = 1'b0;
    end else if (char_en && terminate_in) begin
      s_d.term = 1'b1;
    end else begin
      s_d.term = s_q.term;
    end

    // Fetch request opens with the hold window and closes at its end or on a terminator.
    if (s_q.term) begin
      s_d.fetch = 1'b0;
    end else if (hold_start && fetch_cond) begin
      s_d.fetch = 1'b1;
    end else if (hold_end) begin
      s_d.fetch = 1'b0;
    end

    // New-zone flag: remember that its own fetch has ended, then wait for the load.
    if (s_q.fetch && !s_d.fetch && s_q.nz) begin
      s_d.nz_done = 1'b1;
    end
    if (row_pointer_load && s_q.nz_done) begin
      s_d.nz      = 1'b0;
      s_d.nz_done = 1'b0;
    end
    // Setting after the clear lets an entry in the same cycle win.
    if (!s_q.scroll_sel && s_d.scroll_sel) begin
      s_d.nz      = 1'b1;
      s_d.nz_done = 1'b0;
    end

    // Internal blank rises with line blank but releases on the next character clock.
    if (line_blank_input) begin
      s_d.vid_blank = 1'b1;
    end else if (char_en) begin
      s_d.vid_blank = 1'b0;
    end
    s_d.video.blank = s_d.vid_blank || (s_d.term && !s_q.ctrl.reverse);
    s_d.video.dim   = !s_d.vid_blank && s_d.term && s_q.ctrl.reverse;

    // Register bus data phase: writes land here, reads were fetched earlier.
    case (s_q.phase)
      BUS_WRITE: begin
        if (s_q.waddr == CTRL_OFS) begin
          s_d.ctrl = ctrl_s'(hwdata[3:0]);
        end
        s_d.phase = BUS_IDLE;
      end
      BUS_IDLE: begin
        s_d.phase = BUS_IDLE;
      end
      default: begin
        s_d.phase = BUS_IDLE;
      end
    endcase

    // Register bus address phase; read data is latched for the following data phase.
    s_d.hrdata = 32'h0000_0000;
    if (addr_phase) begin
      if (hwrite && hsize == HSIZE_WORD) begin
        s_d.phase = BUS_WRITE;
        s_d.waddr = haddr;
      end else if (!hwrite && haddr == CTRL_OFS) begin
        s_d.hrdata = {28'h0000000, s_q.ctrl};
      end else if (!hwrite && haddr == STAT_OFS) begin
        s_d.hrdata[STAT_SCAN_LSB +: 4] = s_q.scan_code;
        s_d.hrdata[STAT_FETCH_BIT]     = s_q.fetch;
        s_d.hrdata[STAT_NZONE_BIT]     = s_q.nz;
        s_d.hrdata[STAT_TERM_BIT]      = s_q.term;
        s_d.hrdata[STAT_SCROLL_BIT]    = s_q.scroll_sel;
        s_d.hrdata[STAT_BLANK_BIT]     = s_q.video.blank;
      end
    end

    // The slave never inserts wait states and always answers OKAY.
    s_d.hreadyout = 1'b1;
    s_d.hresp     = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register with synchronous reset.
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      s_q <= STATE_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // Every output comes straight from the state register.
  assign scan_code = s_q.scan_code;
  assign fetch_req = s_q.fetch;
  assign line_tick = s_q.line_tick;
  assign video     = s_q.video;
  assign hreadyout = s_q.hreadyout;
  assign hrdata    = s_q.hrdata;
  assign hresp     = s_q.hresp;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks on the scan code path.
  chk_scan_hold: assert property (@(posedge mclk) disable iff (!rst_b)
    !line_rise |=> $stable(scan_code))
    else $error("scan code changed without a blank rise");

  chk_scan_normal: assert property (@(posedge mclk) disable iff (!rst_b)
    line_rise && !s_q.ctrl.dh |=> scan_code == 4'($past(sel_cnt) - 4'h1))
    else $error("normal scan code is not count minus one");

  chk_scan_top_half: assert property (@(posedge mclk) disable iff (!rst_b)
    line_rise && s_q.ctrl.dh && !s_q.ctrl.bottom
      |=> scan_code == 4'({1'b0, $past(sel_cnt[3:1])} - 4'h1))
    else $error("top half scan code is wrong");

  chk_scan_bottom_half: assert property (@(posedge mclk) disable iff (!rst_b)
    line_rise && s_q.ctrl.dh && s_q.ctrl.bottom
      |=> scan_code == 4'({1'b0, $past(sel_cnt[3:1])} + 4'h4))
    else $error("bottom half scan code is wrong");

  // Checks on the fetch request.
  chk_fetch_start: assert property (@(posedge mclk) disable iff (!rst_b)
    hold_start && fetch_cond && !s_q.term |=> fetch_req)
    else $error("fetch not raised at hold window open");

  chk_fetch_window: assert property (@(posedge mclk) disable iff (!rst_b)
    fetch_req |-> (s_q.win >= HOLD_OPEN) && (s_q.win <= HOLD_CLOSE))
    else $error("fetch request outside the hold window");

  chk_fetch_term: assert property (@(posedge mclk) disable iff (!rst_b)
    s_q.term |=> !fetch_req)
    else $error("fetch request survives a terminator");

  // Checks on the terminate flag, the new-zone flag and video blanking during line blank.
  chk_term_latch: assert property (@(posedge mclk) disable iff (!rst_b)
    s_q.term && !term_clr |=> s_q.term)
    else $error("terminate flag dropped without its clear");

  chk_term_clear: assert property (@(posedge mclk) disable iff (!rst_b)
    line_blank_input && s_q.blank_prev && s_q.win != 3'h0 |=> !s_q.term)
    else $error("terminate flag not cleared during line blank");

  chk_new_zone: assert property (@(posedge mclk) disable iff (!rst_b)
    $rose(s_q.scroll_sel) |-> s_q.nz)
    else $error("scroll entry did not set the new-zone flag");

  chk_video_blank: assert property (@(posedge mclk) disable iff (!rst_b)
    line_blank_input |=> video.blank && !video.dim)
    else $error("video not blanked during line blank");

  ////////////////////////////////////////////////////////////////////////////////
  // Line tick is a single pulse right after each blank rise.
  chk_tick_rise: assert property (@(posedge mclk) disable iff (!rst_b)
    line_rise |=> line_tick)
    else $error("line tick missing after blank rise");

  chk_tick_single: assert property (@(posedge mclk) disable iff (!rst_b)
    line_tick |=> !line_tick)
    else $error("line tick longer than one cycle");

  // A fetch opens only at the hold window, and only for a row start or a new zone.
  chk_fetch_cause: assert property (@(posedge mclk) disable iff (!rst_b)
    $rose(fetch_req) |-> $past(hold_start) && $past(fetch_cond))
    else $error("fetch request raised without a cause");

  chk_fetch_end: assert property (@(posedge mclk) disable iff (!rst_b)
    fetch_req && hold_end |=> !fetch_req)
    else $error("fetch request outlived the hold window");

  // The terminate input only counts on a character tick, so bus noise between ticks is harmless.
  chk_term_tick: assert property (@(posedge mclk) disable iff (!rst_b)
    !char_en && !s_q.term |=> !s_q.term)
    else $error("terminate flag set between character ticks");

  chk_term_catch: assert property (@(posedge mclk) disable iff (!rst_b)
    char_en && terminate_in && !term_clr |=> s_q.term)
    else $error("terminator on a character tick was missed");

  // After a terminator the line shows black in normal screen and dim in reverse screen.
  chk_term_black: assert property (@(posedge mclk) disable iff (!rst_b)
    s_q.term && !term_clr && !s_q.ctrl.reverse |=> video.blank && !video.dim)
    else $error("terminator did not blank normal screen");

  chk_term_dim: assert property (@(posedge mclk) disable iff (!rst_b)
    s_q.term && !term_clr && s_q.ctrl.reverse && !line_blank_input && !s_q.vid_blank
      |=> video.dim && !video.blank)
    else $error("terminator did not dim reverse screen");

  // Video stays blanked until the character tick that follows the fall of line blank.
  chk_blank_hold: assert property (@(posedge mclk) disable iff (!rst_b)
    s_q.vid_blank && !char_en |=> video.blank)
    else $error("video released between character ticks");

  chk_blank_release: assert property (@(posedge mclk) disable iff (!rst_b)
    !line_blank_input && char_en && !s_q.term && !terminate_in |=> !video.blank)
    else $error("video not released on the character tick");

  // The new-zone flag is only given up by the load that follows its own fetch.
  chk_zone_hold: assert property (@(posedge mclk) disable iff (!rst_b)
    s_q.nz && !(row_pointer_load && s_q.nz_done) |=> s_q.nz)
    else $error("new-zone flag dropped without its load");

  chk_zone_clear: assert property (@(posedge mclk) disable iff (!rst_b)
    s_q.nz && s_q.nz_done && row_pointer_load && s_q.scroll_sel |=> !s_q.nz)
    else $error("new-zone flag survived the row pointer load");

  // Scroll select only moves on a base counter boundary inside the boundary window.
  chk_scroll_boundary: assert property (@(posedge mclk) disable iff (!rst_b)
    !(bnd_win && base_scan == 4'h0) |=> $stable(s_q.scroll_sel))
    else $error("scroll select moved off a boundary");

  // Fetch and new-zone flag come out of reset idle; this one watches the reset itself.
  chk_reset_idle: assert property (@(posedge mclk)
    !rst_b |=> !fetch_req && !s_q.nz)
    else $error("fetch or new-zone flag active after reset");

endmodule // scan_fetch_ctrl

// >>> core/scan_fetch_pkg.sv
// Shared constants and types for the scan code and line fetch control block.
// Assumes a single 250 MHz clock and an AHB-Lite register slave with 32-bit data.
package scan_fetch_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register map, byte addresses on the register bus.
  localparam logic [31:0] CTRL_OFS = 32'h0000_0000;
  localparam logic [31:0] STAT_OFS = 32'h0000_0004;

  // Control register fields.
  localparam int          CTRL_DH_BIT      = 0;
  localparam int          CTRL_BOTTOM_BIT  = 1;
  localparam int          CTRL_SCROLL_BIT  = 2;
  localparam int          CTRL_REVERSE_BIT = 3;
  localparam logic [3:0]  CTRL_RESET       = 4'h0;

  // Status register fields.
  localparam int          STAT_SCAN_LSB    = 0;
  localparam int          STAT_FETCH_BIT   = 4;
  localparam int          STAT_NZONE_BIT   = 5;
  localparam int          STAT_TERM_BIT    = 6;
  localparam int          STAT_SCROLL_BIT  = 7;
  localparam int          STAT_BLANK_BIT   = 8;

  // Bus encodings.
  localparam logic [2:0]  HSIZE_WORD       = 3'h2;

  ////////////////////////////////////////////////////////////////////////////////
  // Line window, counted in character times after the rise of line blank.
  localparam logic [2:0]  BND_OPEN         = 3'h1;
  localparam logic [2:0]  BND_CLOSE        = 3'h2;
  localparam logic [2:0]  HOLD_OPEN        = 3'h3;
  localparam logic [2:0]  HOLD_CLOSE       = 3'h5;
  localparam logic [2:0]  TCLR_START       = 3'h1;
  localparam logic [2:0]  WIN_IDLE         = 3'h7;

  // Scan code arithmetic.
  localparam logic [3:0]  SCAN_STEP        = 4'h1;
  localparam logic [3:0]  BOTTOM_ADD       = 4'h4;
  localparam logic [3:0]  SCAN_RESET       = 4'h0;

  ////////////////////////////////////////////////////////////////////////////////
  // Software control bits, in the order of their register positions.
  typedef struct packed {
    logic reverse;
    logic scroll;
    logic bottom;
    logic dh;
  } ctrl_s;

  // Video gating towards the output stage.
  typedef struct packed {
    logic blank;
    logic dim;
  } video_s;

  // Data phase of the register bus.
  typedef enum logic [0:0] {
    BUS_IDLE  = 1'b0,
    BUS_WRITE = 1'b1
  } bus_phase_e;

  // Whole state of the top module.
  typedef struct packed {
    logic [7:0]  div;
    logic        blank_prev;
    logic [2:0]  win;
    logic [3:0]  scan_code;
    logic        line_tick;
    logic        fetch;
    logic        nz;
    logic        nz_done;
    logic        term;
    logic        scroll_sel;
    logic        vid_blank;
    video_s      video;
    ctrl_s       ctrl;
    bus_phase_e  phase;
    logic [31:0] waddr;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
  } state_s;

endpackage

// >>> core/scan_math.sv
// Scan code arithmetic for normal and double-height character rows.
// Assumes the selected counter value is already chosen by the caller.
module scan_math (
  // Selected counter and row attributes.
  input  wire logic [3:0] sel_cnt,
  input  wire logic       dh,
  input  wire logic       bottom,
  // Resulting scan code.
  output logic      [3:0] code
);
  import scan_fetch_pkg::*;

  logic [3:0] half;

  ////////////////////////////////////////////////////////////////////////////////
  // Halving first keeps each font scan on two display scans in double height.
  always_comb begin
    half = {1'b0, sel_cnt[3:1]};
    if (!dh) begin
      code = sel_cnt - SCAN_STEP;
    end else if (!bottom) begin
      code = half - SCAN_STEP;
    end else begin
      code = half + BOTTOM_ADD;
    end
  end

endmodule // scan_math

// >>> bench/line_timing_model.sv
// Far-side model of the video timing generator: one scan line per start pulse.
// Assumes one clock shared with the block; a character time is CD clocks.
module line_timing_model #(
  parameter int CD  = 2,
  parameter int BLK = 3,
  parameter int ACT = 8
) (
  // Clock and reset.
  input  wire logic       mclk,
  input  wire logic       rst_b,
  // Line request from the bench, terminator position 1-based, 0 for none.
  input  wire logic       start,
  input  wire logic [7:0] term_char,
  // Line timing towards the block.
  output logic            line_blank_input,
  output logic            terminate_in,
  output logic            busy
);
  timeunit 1ns;
  timeprecision 100ps;
  int   cyc_q;
  logic in_blank;
  logic junk;
  logic hit;

  ////////////////////////////////////////////////////////////////////////////////
  // Line position counter, restarted by each start pulse.
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      cyc_q <= 0;
    end else if (start) begin
      cyc_q <= 1;
    end else if (cyc_q != 0 && cyc_q < (BLK + ACT) * CD) begin
      cyc_q <= cyc_q + 1;
    end else begin
      cyc_q <= 0;
    end
  end

  // Blank drops at the first visible character boundary, ahead of unblanking.
  assign in_blank = cyc_q != 0 && cyc_q <= BLK * CD;
  // The data bus carries stray terminators during blank, to prove they are ignored.
  assign junk = in_blank && cyc_q > 2 * CD && cyc_q < BLK * CD && cyc_q[0];
  // A real terminator fills one whole character time so a character tick sees it.
  assign hit = term_char != 8'h00 && cyc_q > (BLK + int'(term_char) - 1) * CD && cyc_q <= (BLK + int'(term_char)) * CD;
  assign line_blank_input = in_blank;
  assign terminate_in = junk || hit;
  assign busy = cyc_q != 0;
endmodule // line_timing_model

// >>> bench/tb.sv
// Self-checking bench for the scan code and line fetch control block.
// Assumes the timing model drives blank and terminate; the bench plays the processor.
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import scan_fetch_pkg::*;
  localparam int CD  = 2;
  localparam int BLK = 3;
  logic        mclk, rst_b, row_pointer_load, hsel, hwrite, start, busy;
  logic        line_blank_input, terminate_in, fetch_req, line_tick, hreadyout, hresp, vb_early;
  logic [3:0]  base_scan, offset_scan, scan_code, sc, e;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  term_char;
  logic [31:0] haddr, hwdata, hrdata, rd;
  video_s      video, vlast;
  int          err_total, tests_run, flen, frise, ticks, rel, cyc;

  scan_fetch_ctrl #(.CHAR_DIV(CD)) i_scan_fetch_ctrl (
    .mclk(mclk), .rst_b(rst_b), .line_blank_input(line_blank_input), .terminate_in(terminate_in),
    .row_pointer_load(row_pointer_load), .base_scan(base_scan), .offset_scan(offset_scan),
    .scan_code(scan_code), .fetch_req(fetch_req), .line_tick(line_tick), .video(video),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp));

  line_timing_model #(.CD(CD), .BLK(BLK), .ACT(8)) i_line_timing_model (
    .mclk(mclk), .rst_b(rst_b), .start(start), .term_char(term_char),
    .line_blank_input(line_blank_input), .terminate_in(terminate_in), .busy(busy));

  ////////////////////////////////////////////////////////////////////////////////
  // Counts a comparison and reports a mismatch at once.
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One single AHB-Lite word transfer; entered just after a rising edge.
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
    while (fetch_req === 1'b1) @(posedge mclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask

  // Runs one scan line and records what the block did; index 1 is the first blank clock.
  task automatic run_line(input logic [7:0] tc);
    term_char <= tc;
    start <= 1'b1;
    @(posedge mclk);
    start <= 1'b0;
    flen = 0;
    frise = 0;
    ticks = 0;
    rel = 0;
    cyc = 0;
    @(posedge mclk);
    while (busy === 1'b1) begin
      cyc++;
      if (fetch_req === 1'b1 && frise == 0) frise = cyc;
      if (fetch_req === 1'b1) flen++;
      if (line_tick === 1'b1) ticks++;
      if (cyc == 4) vb_early = video.blank;
      if (cyc > BLK * CD && video.blank === 1'b1) rel++;
      vlast = video;
      @(posedge mclk);
    end
    sc = scan_code;
    check("line tick count", 32'h1, 32'(ticks));
    check("blank during line blank", 32'h1, {31'h0, vb_early});
    if (tc == 8'h00) begin
      check("video at line end", 32'h0, {30'h0, vlast});
      check("video release delay", 32'h1, 32'(rel >= 1 && rel <= CD + 1));
    end
    if (tc == 8'h00 && flen > 0) begin
      check("fetch length", 32'(3 * CD), 32'(flen));
      check("fetch start", 32'h1, 32'(frise >= 2 * CD + 2 && frise <= 3 * CD + 3));
    end
  endtask

  // Prints the verdict and ends the run.
  task automatic report_and_stop();
    if (err_total == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Free-running master clock; a character time is CD of its periods.
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // The whole run is under a thousand clocks; this span leaves wide margin.
  initial begin
    repeat (20000) @(posedge mclk);
    err_total++;
    report_and_stop();
  end

  // Main sequence.
  initial begin
    {rst_b, row_pointer_load, hsel, hwrite, start, htrans, haddr, hwdata} = '0;
    {base_scan, offset_scan, term_char, err_total, tests_run} = '0;
    hsize = HSIZE_WORD;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    check("reset outputs", 32'h0000_0102, {23'h0, hreadyout, hresp, fetch_req, scan_code, video});
    repeat (8) @(posedge mclk);
    check("fetch idle", 32'h0, {31'h0, fetch_req});
    bus(1'b0, CTRL_OFS, 32'h0, rd);
    check("ctrl reset", 32'(CTRL_RESET), rd);
    bus(1'b1, CTRL_OFS, 32'hFFFF_FFFF, rd);
    bus(1'b0, CTRL_OFS, 32'h0, rd);
    check("ctrl width", 32'h0000_000F, rd);
    bus(1'b0, 32'h0000_0008, 32'h0, rd);
    check("unmapped read", 32'h0, rd);
    // Scan code math for normal, top and bottom rows over a full character row.
    for (int m = 0; m < 3; m++) begin
      for (int n = 0; n < 10; n++) begin
        bus(1'b1, CTRL_OFS, (m == 0) ? 32'h0 : (m == 1) ? 32'h1 : 32'h3, rd);
        base_scan <= 4'(n);
        offset_scan <= 4'(9 - n);
        @(posedge mclk);
        run_line(8'h00);
        e = (m == 0) ? 4'(n) - 4'h1 : (m == 1) ? (4'(n) >> 1) - 4'h1 : (4'(n) >> 1) + 4'h4;
        check("scan code", 32'(e), 32'(sc));
        check("fetch on row start", 32'(n == 0), 32'(flen > 0));
      end
    end
    base_scan <= 4'h7;
    repeat (4) @(posedge mclk);
    check("scan code held", 32'h8, 32'(scan_code));
    // A terminator cuts the fetch short and blanks or dims the rest of the line.
    for (int m = 0; m < 2; m++) begin
      bus(1'b1, CTRL_OFS, m ? 32'h8 : 32'h0, rd);
      base_scan <= 4'h0;
      run_line(8'h02);
      check("fetch cut", 32'h1, 32'(flen > 0 && flen < 3 * CD));
      check("video after term", m ? 32'h1 : 32'h2, {30'h0, vlast});
      bus(1'b0, STAT_OFS, 32'h0, rd);
      check("term flag", 32'h1, {31'h0, rd[STAT_TERM_BIT]});
    end
    // Entering a scroll region forces fetches until the row pointer load.
    bus(1'b1, CTRL_OFS, 32'h4, rd);
    offset_scan <= 4'h5;
    run_line(8'h00);
    bus(1'b0, STAT_OFS, 32'h0, rd);
    check("scroll and zone", 32'h3, {30'h0, rd[STAT_SCROLL_BIT], rd[STAT_NZONE_BIT]});
    base_scan <= 4'h1;
    offset_scan <= 4'h6;
    run_line(8'h00);
    check("forced fetch", 32'h1, 32'(flen > 0));
    check("offset scan code", 32'h5, 32'(sc));
    row_pointer_load <= 1'b1;
    @(posedge mclk);
    row_pointer_load <= 1'b0;
    @(posedge mclk);
    bus(1'b0, STAT_OFS, 32'h0, rd);
    check("zone cleared", 32'h0, {31'h0, rd[STAT_NZONE_BIT]});
    base_scan <= 4'h2;
    offset_scan <= 4'h7;
    run_line(8'h00);
    check("no fetch after load", 32'h0, 32'(flen));
    check("offset scan code", 32'h6, 32'(sc));
    report_and_stop();
  end
endmodule // tb
